// file: hdl/spid_decoder.sv
// spid_decoder: registered decoder of 32-bit instruction words.
// assumes instr_word is stable with instr_valid on the same clock.
// Summary of operation
// RULE1: bit 31 makes the word's count of ones odd.
// RULE2: bits 30-29 pick float formats 1-3; ones in 30-27 pick format 4.
// RULE3: format 4 conversion code 0-5 picks the operation, above is reserved.
// RULE4: source accumulator code picks acc 0-3, constant 0.0 or 1.0.
// RULE5: each sign bit means add when 0, subtract when 1.
// RULE6: operand field splits into 4-bit pointer and 3-bit increment.
// RULE7: 2-bit destination code picks accumulator 0 to 3.
// RULE8: pointer 1-14 selects register, 0 direct, 15 reuses previous pointer.
// RULE9: increment picks none, registers 15-19, or post step down/up.
// RULE10: zero pointer makes increment a direct operand with slot limits.
// RULE11: bits 30-26 and 25 select the control-arithmetic format.
// RULE12: condition prefix picks integer, float or I/O tests; some reserved.
// RULE13: sense bit picks branch on false or on true.
// RULE14: move direction bit: 0 into register, 1 out to memory.
// RULE15: width 00 high byte, 01 low byte, 1x 16-bit integer.
// RULE16: arithmetic/logic function code, four codes reserved.
// RULE17: 5-bit register code, codes above control words reserved.
// RULE18: zero move pointer selects I/O move; some pointer codes reserved.
// RULE19: move increment code picks register, zero, or post step.
// RULE20: low 16 bits carry the immediate or address.
// RULE21: I/O operand field decoded only when move pointer is zero.
// RULE22: control word loads take 16 bits or only 3 bits.
// RULE23: bad parity or reserved codes raise an error indication.
`timescale 1ns/1ps
`default_nettype none
module spid_decoder (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  output logic dec_valid_r,
  output logic parity_err_r,
  output logic reserved_err_r,
  output logic is_float_op_r,
  output logic is_int_op_r,
  output logic [2:0] da_format_r,
  output logic [3:0] conv_op_r,
  output logic [1:0] src_acc_r,
  output logic [1:0] src_kind_r,
  output logic sub_f_r,
  output logic sub_s_r,
  output logic [1:0] dst_acc_r,
  output logic [2:0][3:0] opnd_ptr_r,
  output logic [2:0][1:0] opnd_step_r,
  output logic [2:0][4:0] opnd_inc_reg_r,
  output logic [2:0] opnd_direct_r,
  output logic [2:0][2:0] opnd_dsel_r,
  output logic [2:0] opnd_step_bytes_r,
  output logic [3:0] ca_format_r,
  output logic [4:0] cond_r,
  output logic [1:0] cond_class_r,
  output logic uncond_r,
  output logic on_true_r,
  output logic [3:0] alu_fn_r,
  output logic [4:0] reg_a_r,
  output logic [4:0] reg_b_r,
  output logic to_mem_r,
  output logic [1:0] width_r,
  output logic [4:0] mem_ptr_r,
  output logic [1:0] mem_step_r,
  output logic [4:0] mem_inc_r,
  output logic [1:0] mem_step_bytes_r,
  output logic io_move_r,
  output logic [4:0] io_sel_r,
  output logic [15:0] imm_r,
  output logic imm_valid_r,
  output logic load_fctl_r,
  output logic load_ioctl_r,
  output logic [15:0] ctl_value_r
);

  function automatic logic rsv_reg(input logic [4:0] c);
    rsv_reg = (c > spid_pkg::REG_IOCTL); // RULE17
  endfunction

  // shared by the move pointer and increment tables
  function automatic logic rsv_upper(input logic [4:0] c);
    rsv_upper = (c == 5'h0F) || (c >= 5'h1A);
  endfunction

  function automatic logic rsv_cond(input logic [4:0] c);
    rsv_cond = (c[4:3] == 2'h3) || (c >= 5'h0D && c <= 5'h0F)
      || (c == 5'h16) || (c == 5'h17); // RULE12
  endfunction

  logic par_err;
  logic [3:0] xp;
  logic [3:0] yp;
  logic [3:0] zp;
  spid_pkg::spid_step_t xs;
  spid_pkg::spid_step_t ys;
  spid_pkg::spid_step_t zs;
  logic [4:0] xi;
  logic [4:0] yi;
  logic [4:0] zi;
  logic xd;
  logic yd;
  logic zd;
  logic [2:0] xsel;
  logic [2:0] ysel;
  logic [2:0] zsel;
  logic xbad;
  logic ybad;
  logic zbad;
  logic is_da;
  logic fmt4;
  logic [4:0] op;

  assign is_da = (instr_word[spid_pkg::MAJ_HI:spid_pkg::MAJ_LO] != 2'h0);
  assign fmt4 = (instr_word[spid_pkg::F4_HI:spid_pkg::F4_LO] == spid_pkg::F4_SEL);
  assign op = instr_word[spid_pkg::OP_HI:spid_pkg::OP_LO];

  spid_parity u_par (
    .word(instr_word),
    .par_err(par_err)
  );

  spid_opnd u_x (
    .field(instr_word[spid_pkg::X_HI:spid_pkg::X_LO]),
    .prev_ptr(4'h0),
    .slot(2'h2),
    .conv(fmt4),
    .used(is_da && !fmt4),
    .ptr(xp),
    .step(xs),
    .inc_reg(xi),
    .direct(xd),
    .dsel(xsel),
    .bad(xbad)
  );

  spid_opnd u_y (
    .field(instr_word[spid_pkg::Y_HI:spid_pkg::Y_LO]),
    .prev_ptr(xp),
    .slot(2'h1),
    .conv(fmt4),
    .used(is_da),
    .ptr(yp),
    .step(ys),
    .inc_reg(yi),
    .direct(yd),
    .dsel(ysel),
    .bad(ybad)
  );

  spid_opnd u_z (
    .field(instr_word[spid_pkg::Z_HI:spid_pkg::Z_LO]),
    .prev_ptr(yp),
    .slot(2'h0),
    .conv(fmt4),
    .used(is_da),
    .ptr(zp),
    .step(zs),
    .inc_reg(zi),
    .direct(zd),
    .dsel(zsel),
    .bad(zbad)
  );

  spid_pkg::spid_dec_t d;
  spid_pkg::spid_dec_t dec_r;
  spid_pkg::spid_dec_t dec_nxt;
  logic dec_valid_nxt;
  logic [2:0] m;
  logic [4:0] pf;
  logic [4:0] inc5;
  logic rsv;

  always_comb
  begin
    d = '0;
    rsv = 1'b0;
    m = instr_word[spid_pkg::M_HI:spid_pkg::M_LO];
    pf = instr_word[spid_pkg::P_HI:spid_pkg::P_LO];
    inc5 = instr_word[spid_pkg::I_HI:spid_pkg::I_LO];
    d.par_err = par_err; // RULE23
    d.imm = instr_word[spid_pkg::IMM_HI:0]; // RULE20
    if (is_da)
    begin
      d.is_float = 1'b1;
      d.da_fmt = fmt4 ? 3'h4 : {1'b0, instr_word[spid_pkg::MAJ_HI:spid_pkg::MAJ_LO]}; // RULE2
      d.dst_acc = instr_word[spid_pkg::N_HI:spid_pkg::N_LO]; // RULE7
      d.ptr = {xp, yp, zp}; // RULE8
      d.step = {xs, ys, zs}; // RULE9
      d.inc_reg = {xi, yi, zi}; // RULE9
      d.direct = {xd, yd, zd}; // RULE10
      d.dsel = {xsel, ysel, zsel}; // RULE10
      d.step_bytes = spid_pkg::STEP_FLT; // RULE9
      rsv = xbad || ybad || zbad; // RULE10
      if (fmt4)
      begin
        d.conv_op = instr_word[spid_pkg::G_HI:spid_pkg::G_LO]; // RULE3
        rsv = rsv || (d.conv_op > spid_pkg::CONV_MAX); // RULE3
      end
      else
      begin
        d.sub_f = instr_word[spid_pkg::F_POS]; // RULE5
        d.sub_s = instr_word[spid_pkg::S_POS]; // RULE5
        d.src_acc = m[1:0]; // RULE4
        if (m == spid_pkg::ACC_ZERO)
          d.src_kind = spid_pkg::SRC_ZERO; // RULE4
        else if (m == spid_pkg::ACC_ONE)
          d.src_kind = spid_pkg::SRC_ONE; // RULE4
        else
          d.src_kind = spid_pkg::SRC_ACC;
        rsv = rsv || (m > spid_pkg::ACC_ONE); // RULE4
      end
    end
    else
    begin
      d.is_int = 1'b1;
      d.reg_a = instr_word[spid_pkg::H_HI:spid_pkg::H_LO]; // RULE17
      if (op[4:1] == 4'h0)
      begin
        d.ca_fmt = spid_pkg::CA_BRANCH; // RULE11
        d.cond = instr_word[spid_pkg::C_HI:spid_pkg::C_LO]; // RULE12
        d.cond_class = d.cond[4:3]; // RULE12
        d.uncond = (d.cond == 5'h00); // RULE12
        d.on_true = instr_word[spid_pkg::SENSE_POS]; // RULE13
        d.imm_vld = 1'b1; // RULE20
        rsv = rsv_cond(d.cond) || rsv_reg(d.reg_a); // RULE12
      end
      else
      begin
        d.reg_b = instr_word[spid_pkg::RA_HI:spid_pkg::RA_LO];
        unique case (op)
          spid_pkg::OP_RSV:
          begin
            d.ca_fmt = spid_pkg::CA_RSV; // RULE11
            rsv = 1'b1; // RULE23
          end
          spid_pkg::OP_LOOP:
          begin
            d.ca_fmt = spid_pkg::CA_LOOP; // RULE11
            d.imm_vld = 1'b1; // RULE20
            rsv = rsv_reg(d.reg_a) || rsv_reg(d.reg_b); // RULE17
          end
          spid_pkg::OP_CALL:
          begin
            d.ca_fmt = spid_pkg::CA_CALL; // RULE11
            d.imm_vld = 1'b1; // RULE20
            rsv = rsv_reg(d.reg_a) || rsv_reg(d.reg_b); // RULE17
          end
          spid_pkg::OP_ADD3:
          begin
            d.ca_fmt = spid_pkg::CA_ADD3; // RULE11
            d.imm_vld = 1'b1; // RULE20
            d.ld_fctl = (d.reg_b == spid_pkg::REG_FCTL); // RULE22
            d.ld_ioctl = (d.reg_b == spid_pkg::REG_IOCTL); // RULE22
            if (d.ld_ioctl)
              d.ctl_val = d.imm; // RULE22
            else if (d.ld_fctl)
              d.ctl_val = {13'h0000, d.imm[spid_pkg::FCTL_W-1:0]}; // RULE22
            rsv = rsv_reg(d.reg_a) || rsv_reg(d.reg_b); // RULE17
          end
          spid_pkg::OP_ALU:
          begin
            // D sits where H does; register source in the S slot
            d.alu_fn = instr_word[spid_pkg::FN_HI:spid_pkg::FN_LO]; // RULE16
            d.reg_b = pf;
            if (instr_word[spid_pkg::VAR_POS])
            begin
              d.ca_fmt = spid_pkg::CA_ALU_IMM; // RULE11
              d.imm_vld = 1'b1; // RULE20
              d.reg_b = 5'h00;
            end
            else
              d.ca_fmt = spid_pkg::CA_ALU_REG; // RULE11
            rsv = (d.alu_fn == 4'h3) || (d.alu_fn == 4'h6) || (d.alu_fn == 4'h9)
              || (d.alu_fn == 4'hB) || rsv_reg(d.reg_a) || rsv_reg(d.reg_b); // RULE16
          end
          spid_pkg::OP_MOVE:
          begin
            d.reg_b = 5'h00;
            d.to_mem = instr_word[spid_pkg::T_POS]; // RULE14
            if (instr_word[spid_pkg::W_HI])
              d.width = spid_pkg::W_INT; // RULE15
            else if (instr_word[spid_pkg::W_LO])
              d.width = spid_pkg::W_LOW; // RULE15
            else
              d.width = spid_pkg::W_HIGH; // RULE15
            rsv = rsv_reg(d.reg_a); // RULE17
            if (!instr_word[spid_pkg::VAR_POS])
            begin
              d.ca_fmt = spid_pkg::CA_MV_DIR; // RULE11
              d.imm_vld = 1'b1; // RULE20
            end
            else if (pf == 5'h00)
            begin
              d.ca_fmt = spid_pkg::CA_MV_IO; // RULE18
              d.io_move = 1'b1; // RULE21
              d.io_sel = inc5; // RULE21
            end
            else
            begin
              d.ca_fmt = spid_pkg::CA_MV_PTR; // RULE18
              d.mptr = pf; // RULE18
              d.minc = inc5; // RULE19
              d.mstep_bytes = instr_word[spid_pkg::W_HI] ? spid_pkg::STEP_INT
                : spid_pkg::STEP_BYTE; // RULE19
              if (inc5 == 5'h16)
                d.mstep = spid_pkg::STEP_DEC; // RULE19
              else if (inc5 == 5'h17)
                d.mstep = spid_pkg::STEP_INC; // RULE19
              else if (inc5 == 5'h10)
                d.mstep = spid_pkg::STEP_NONE; // RULE19
              else
                d.mstep = spid_pkg::STEP_REG; // RULE19
              rsv = rsv || rsv_upper(pf) || (pf == 5'h10) || (pf == 5'h16)
                || (pf == 5'h17) || rsv_upper(inc5) || (inc5 == 5'h00); // RULE18
            end
          end
          default: d.ca_fmt = spid_pkg::CA_NONE;
        endcase
      end
    end
    d.rsv_err = rsv; // RULE23
  end

  // fields hold between words so the units can sample them late
  always_comb
  begin
    dec_valid_nxt = instr_valid;
    dec_nxt = instr_valid ? d : dec_r;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dec_valid_r <= 1'b0;
      dec_r <= '0;
    end
    else
    begin
      dec_valid_r <= dec_valid_nxt;
      dec_r <= dec_nxt;
    end
  end

  assign parity_err_r = dec_r.par_err;
  assign reserved_err_r = dec_r.rsv_err;
  assign is_float_op_r = dec_r.is_float;
  assign is_int_op_r = dec_r.is_int;
  assign da_format_r = dec_r.da_fmt;
  assign conv_op_r = dec_r.conv_op;
  assign src_acc_r = dec_r.src_acc;
  assign src_kind_r = dec_r.src_kind;
  assign sub_f_r = dec_r.sub_f;
  assign sub_s_r = dec_r.sub_s;
  assign dst_acc_r = dec_r.dst_acc;
  assign opnd_ptr_r = dec_r.ptr;
  assign opnd_step_r = dec_r.step;
  assign opnd_inc_reg_r = dec_r.inc_reg;
  assign opnd_direct_r = dec_r.direct;
  assign opnd_dsel_r = dec_r.dsel;
  assign opnd_step_bytes_r = dec_r.step_bytes;
  assign ca_format_r = dec_r.ca_fmt;
  assign cond_r = dec_r.cond;
  assign cond_class_r = dec_r.cond_class;
  assign uncond_r = dec_r.uncond;
  assign on_true_r = dec_r.on_true;
  assign alu_fn_r = dec_r.alu_fn;
  assign reg_a_r = dec_r.reg_a;
  assign reg_b_r = dec_r.reg_b;
  assign to_mem_r = dec_r.to_mem;
  assign width_r = dec_r.width;
  assign mem_ptr_r = dec_r.mptr;
  assign mem_step_r = dec_r.mstep;
  assign mem_inc_r = dec_r.minc;
  assign mem_step_bytes_r = dec_r.mstep_bytes;
  assign io_move_r = dec_r.io_move;
  assign io_sel_r = dec_r.io_sel;
  assign imm_r = dec_r.imm;
  assign imm_valid_r = dec_r.imm_vld;
  assign load_fctl_r = dec_r.ld_fctl;
  assign load_ioctl_r = dec_r.ld_ioctl;
  assign ctl_value_r = dec_r.ctl_val;

  parity_flag_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE1
    instr_valid |=> dec_valid_r && (parity_err_r == ~(^$past(instr_word))))
    else $error("parity flag wrong");

  float_format_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE2
    instr_valid && instr_word[30:27] == 4'hF |=> da_format_r == 3'h4 && is_float_op_r)
    else $error("format 4 not selected");

  conv_reserved_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE3
    instr_valid && instr_word[30:27] == 4'hF && instr_word[26:23] > 4'h5
    |=> reserved_err_r)
    else $error("reserved conversion passed");

  src_const_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE4
    instr_valid && instr_word[30:29] == 2'h1 && instr_word[28:26] == 3'h5
    |=> src_kind_r == 2'h2)
    else $error("constant 1.0 not chosen");

  dest_acc_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE7
    instr_valid && instr_word[30:29] != 2'h0 |=> dst_acc_r == $past(instr_word[22:21]))
    else $error("destination accumulator wrong");

  branch_sense_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE13
    instr_valid && instr_word[30:27] == 4'h0
    |=> ca_format_r == 4'h1 && on_true_r == $past(instr_word[21]))
    else $error("branch sense wrong");

  io_ignore_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE21
    instr_valid && instr_word[30:25] == 6'h0F && instr_word[9:5] != 5'h00
    |=> !io_move_r && io_sel_r == 5'h00)
    else $error("io field decoded with pointer");

  fctl_width_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE22
    load_fctl_r |-> ctl_value_r[15:3] == 13'h0000)
    else $error("float control value too wide");

  hold_fields_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE20
    !instr_valid |=> !dec_valid_r && $stable(imm_r) && $stable(ca_format_r))
    else $error("fields changed without a word");

endmodule
`default_nettype wire

// file: hdl/spid_pkg.sv
// spid_pkg: field positions, codes and the decoded-word record for the
// instruction decoder of the floating-point signal processor.
// assumes a 32-bit instruction word; no registers reached by software.
package spid_pkg;

  // common and data-arithmetic field positions
  localparam int PAR_POS = 31;
  localparam int MAJ_HI = 30;
  localparam int MAJ_LO = 29;
  localparam int F4_HI = 30;
  localparam int F4_LO = 27;
  localparam int M_HI = 28;
  localparam int M_LO = 26;
  localparam int F_POS = 24;
  localparam int S_POS = 23;
  localparam int N_HI = 22;
  localparam int N_LO = 21;
  localparam int G_HI = 26;
  localparam int G_LO = 23;
  localparam int X_HI = 20;
  localparam int X_LO = 14;
  localparam int Y_HI = 13;
  localparam int Y_LO = 7;
  localparam int Z_HI = 6;
  localparam int Z_LO = 0;

  // control-arithmetic field positions
  localparam int OP_HI = 30;
  localparam int OP_LO = 26;
  localparam int VAR_POS = 25;
  localparam int C_HI = 26;
  localparam int C_LO = 22;
  localparam int SENSE_POS = 21;
  localparam int H_HI = 20;
  localparam int H_LO = 16;
  localparam int RA_HI = 25;
  localparam int RA_LO = 21;
  localparam int FN_HI = 24;
  localparam int FN_LO = 21;
  localparam int T_POS = 24;
  localparam int W_HI = 23;
  localparam int W_LO = 22;
  localparam int P_HI = 9;
  localparam int P_LO = 5;
  localparam int I_HI = 4;
  localparam int I_LO = 0;
  localparam int IMM_HI = 15;

  // codes
  localparam logic [3:0] F4_SEL = 4'hF;
  localparam logic [3:0] CONV_MAX = 4'h5;
  localparam logic [2:0] ACC_ZERO = 3'h4;
  localparam logic [2:0] ACC_ONE = 3'h5;
  localparam logic [4:0] OP_RSV = 5'h02;
  localparam logic [4:0] OP_LOOP = 5'h03;
  localparam logic [4:0] OP_CALL = 5'h04;
  localparam logic [4:0] OP_ADD3 = 5'h05;
  localparam logic [4:0] OP_ALU = 5'h06;
  localparam logic [4:0] OP_MOVE = 5'h07;
  localparam logic [4:0] REG_FCTL = 5'h1A;
  localparam logic [4:0] REG_IOCTL = 5'h1B;
  localparam logic [2:0] FCTL_W = 3'h3;
  localparam logic [2:0] DA_NONE = 3'h0;
  localparam logic [2:0] STEP_FLT = 3'h4;
  localparam logic [1:0] STEP_INT = 2'h2;
  localparam logic [1:0] STEP_BYTE = 2'h1;
  localparam logic [1:0] SRC_ACC = 2'h0;
  localparam logic [1:0] SRC_ZERO = 2'h1;
  localparam logic [1:0] SRC_ONE = 2'h2;
  localparam logic [1:0] CC_INT = 2'h0;
  localparam logic [1:0] CC_FLT = 2'h1;
  localparam logic [1:0] CC_IO = 2'h2;

  typedef enum logic [1:0] {
    STEP_NONE = 2'h0,
    STEP_REG = 2'h1,
    STEP_DEC = 2'h2,
    STEP_INC = 2'h3
  } spid_step_t;

  typedef enum logic [1:0] {
    W_HIGH = 2'h0,
    W_LOW = 2'h1,
    W_INT = 2'h2
  } spid_width_t;

  typedef enum logic [3:0] {
    CA_NONE = 4'h0,
    CA_BRANCH = 4'h1,
    CA_RSV = 4'h2,
    CA_LOOP = 4'h3,
    CA_CALL = 4'h4,
    CA_ADD3 = 4'h5,
    CA_ALU_REG = 4'h6,
    CA_ALU_IMM = 4'h7,
    CA_MV_DIR = 4'h8,
    CA_MV_PTR = 4'h9,
    CA_MV_IO = 4'hA
  } spid_ca_fmt_t;

  // one decoded word, registered whole so every output comes from a flop
  typedef struct packed {
    logic par_err, rsv_err, is_float, is_int;
    logic [2:0] da_fmt;
    logic [3:0] conv_op;
    logic [1:0] src_acc, src_kind;
    logic sub_f, sub_s;
    logic [1:0] dst_acc;
    logic [2:0][3:0] ptr;
    logic [2:0][1:0] step;
    logic [2:0][4:0] inc_reg;
    logic [2:0] direct;
    logic [2:0][2:0] dsel;
    logic [2:0] step_bytes;
    spid_ca_fmt_t ca_fmt;
    logic [4:0] cond;
    logic [1:0] cond_class;
    logic uncond, on_true;
    logic [3:0] alu_fn;
    logic [4:0] reg_a, reg_b;
    logic to_mem;
    logic [1:0] width;
    logic [4:0] mptr;
    logic [1:0] mstep;
    logic [4:0] minc;
    logic [1:0] mstep_bytes;
    logic io_move;
    logic [4:0] io_sel;
    logic [15:0] imm;
    logic imm_vld, ld_fctl, ld_ioctl;
    logic [15:0] ctl_val;
  } spid_dec_t;

endpackage

// file: hdl/spid_parity.sv
// spid_parity: odd-parity check of one instruction word.
// assumes nothing; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module spid_parity (
  input wire logic [31:0] word,
  output logic par_err
);

  // the whole word must hold an odd count of ones
  assign par_err = ~(^word); // RULE1

endmodule
`default_nettype wire

// file: hdl/spid_opnd.sv
// spid_opnd: decodes one 7-bit X, Y or Z operand field.
// assumes the caller chains prev_ptr from the preceding field.
`timescale 1ns/1ps
`default_nettype none
module spid_opnd (
  input wire logic [6:0] field,
  input wire logic [3:0] prev_ptr,
  input wire logic [1:0] slot,
  input wire logic conv,
  input wire logic used,
  output logic [3:0] ptr,
  output spid_pkg::spid_step_t step,
  output logic [4:0] inc_reg,
  output logic direct,
  output logic [2:0] dsel,
  output logic bad
);

  logic [3:0] p;
  logic [2:0] i;
  logic slot_x;
  logic slot_z;
  logic fault;

  assign p = field[6:3]; // RULE6
  assign i = field[2:0]; // RULE6
  assign slot_x = (slot == 2'h2);
  assign slot_z = (slot == 2'h0);
  assign bad = used & fault;

  always_comb
  begin
    ptr = p;
    step = spid_pkg::STEP_NONE;
    inc_reg = 5'h00;
    direct = 1'b0;
    dsel = 3'h0;
    fault = 1'b0;
    if (p == 4'h0)
    begin
      direct = 1'b1; // RULE8
      dsel = i; // RULE10
      unique case (i)
        3'h5: fault = !slot_z; // RULE10
        3'h6: fault = slot_x || !conv; // RULE10
        3'h7: fault = !slot_z; // RULE10
        default: fault = slot_z; // RULE10
      endcase
    end
    else
    begin
      // X has no earlier pointer to reuse
      if (p == 4'hF)
      begin
        ptr = prev_ptr; // RULE8
        fault = slot_x;
      end
      unique case (i)
        3'h0: step = spid_pkg::STEP_NONE; // RULE9
        3'h6: step = spid_pkg::STEP_DEC; // RULE9
        3'h7: step = spid_pkg::STEP_INC; // RULE9
        default:
        begin
          step = spid_pkg::STEP_REG; // RULE9
          inc_reg = 5'(i) + 5'h0E; // RULE9
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// file: sim/test_signal_proc_instr_decoder.sv
// test_signal_proc_instr_decoder: self-checking bench for spid_decoder.
// assumes a decoded record one cycle after each word taken with instr_valid.
`timescale 1ns/1ps
`default_nettype none
module test_signal_proc_instr_decoder;
  typedef struct packed {logic [30:0] b; logic rsv; logic [2:0] da; logic [3:0] ca;} spid_row_t;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic instr_valid = 1'b0;
  logic [31:0] instr_word = 32'h0;
  logic dec_valid_r, parity_err_r, reserved_err_r, is_float_op_r, is_int_op_r, sub_f_r, sub_s_r;
  logic uncond_r, on_true_r, to_mem_r, io_move_r, imm_valid_r, load_fctl_r, load_ioctl_r;
  logic [1:0] src_acc_r, src_kind_r, dst_acc_r, cond_class_r, width_r, mem_step_r;
  logic [1:0] mem_step_bytes_r;
  logic [2:0] da_format_r, opnd_direct_r, opnd_step_bytes_r;
  logic [3:0] ca_format_r, conv_op_r, alu_fn_r;
  logic [4:0] cond_r, reg_a_r, mem_ptr_r, reg_b_r, mem_inc_r, io_sel_r;
  logic [15:0] imm_r, ctl_value_r;
  logic [2:0][3:0] opnd_ptr_r;
  logic [2:0][1:0] opnd_step_r;
  logic [2:0][4:0] opnd_inc_reg_r;
  logic [2:0][2:0] opnd_dsel_r;
  int n_errors = 0;
  int samples_checked = 0;
  // body only; parity is added on the way in
  spid_row_t rows [17] = '{
    '{31'h20220887, 1'b0, 3'h1, 4'h0}, '{31'h58020887, 1'b1, 3'h2, 4'h0},
    '{31'h74020887, 1'b0, 3'h3, 4'h0}, '{31'h7A800887, 1'b0, 3'h4, 4'h0},
    '{31'h7B000887, 1'b1, 3'h4, 4'h0}, '{31'h00000000, 1'b0, 3'h0, 4'h1},
    '{31'h08000000, 1'b1, 3'h0, 4'h2}, '{31'h0C200000, 1'b0, 3'h0, 4'h3},
    '{31'h10000000, 1'b0, 3'h0, 4'h4}, '{31'h14000000, 1'b0, 3'h0, 4'h5},
    '{31'h18000000, 1'b0, 3'h0, 4'h6}, '{31'h1A600000, 1'b1, 3'h0, 4'h7},
    '{31'h1C000000, 1'b0, 3'h0, 4'h8}, '{31'h1E200030, 1'b0, 3'h0, 4'h9},
    '{31'h03400000, 1'b1, 3'h0, 4'h1}, '{31'h0C1C0000, 1'b1, 3'h0, 4'h3},
    '{31'h1E000004, 1'b0, 3'h0, 4'hA}};

  spid_decoder i_dut (
    .clk(clk), .reset_n(reset_n), .instr_valid(instr_valid), .instr_word(instr_word),
    .dec_valid_r(dec_valid_r), .parity_err_r(parity_err_r), .reserved_err_r(reserved_err_r),
    .is_float_op_r(is_float_op_r), .is_int_op_r(is_int_op_r), .da_format_r(da_format_r),
    .conv_op_r(conv_op_r), .src_acc_r(src_acc_r), .src_kind_r(src_kind_r), .sub_f_r(sub_f_r),
    .sub_s_r(sub_s_r), .dst_acc_r(dst_acc_r), .opnd_ptr_r(opnd_ptr_r),
    .opnd_step_r(opnd_step_r), .opnd_inc_reg_r(opnd_inc_reg_r), .opnd_direct_r(opnd_direct_r),
    .opnd_dsel_r(opnd_dsel_r), .opnd_step_bytes_r(opnd_step_bytes_r),
    .ca_format_r(ca_format_r), .cond_r(cond_r), .cond_class_r(cond_class_r),
    .uncond_r(uncond_r), .on_true_r(on_true_r), .alu_fn_r(alu_fn_r), .reg_a_r(reg_a_r),
    .reg_b_r(reg_b_r),
    .to_mem_r(to_mem_r), .width_r(width_r), .mem_ptr_r(mem_ptr_r), .mem_step_r(mem_step_r),
    .mem_inc_r(mem_inc_r), .mem_step_bytes_r(mem_step_bytes_r), .io_move_r(io_move_r),
    .io_sel_r(io_sel_r),
    .imm_r(imm_r), .imm_valid_r(imm_valid_r), .load_fctl_r(load_fctl_r),
    .load_ioctl_r(load_ioctl_r), .ctl_value_r(ctl_value_r)
  );

  always #25 clk = ~clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t ns: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  function automatic logic [31:0] fp(input logic [30:0] b);
    return {~^b, b};
  endfunction

  // one idle cycle after each word, so the one-cycle valid is seen alone
  task automatic send(input logic [31:0] w);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_word <= w;
    @(posedge clk);
    instr_valid <= 1'b0;
    @(negedge clk);
  endtask

  task automatic test_done;
    $display("%0d compares, %0d errors", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (3000) @(posedge clk);
    n_errors++;
    $display("Error at %0t ns: run timed out", $time);
    test_done();
  end

  initial
  begin
    repeat (19) @(posedge clk);
    @(negedge clk);
    chk(16'(dec_valid_r), 16'h0, "valid in reset");
    chk(16'(ca_format_r), 16'h0, "format in reset");
    @(posedge clk);
    reset_n <= 1'b1;
    $display("test reset done");
    foreach (rows[k])
    begin
      send(fp(rows[k].b));
      chk(16'(dec_valid_r), 16'h1, "valid");
      chk(16'(parity_err_r), 16'h0, "parity");
      chk(16'(reserved_err_r), 16'(rows[k].rsv), "reserved");
      chk(16'(da_format_r), 16'(rows[k].da), "float format");
      chk(16'(is_float_op_r), 16'(rows[k].ca == 4'h0), "float kind");
      chk(16'(ca_format_r), 16'(rows[k].ca), "int format");
    end
    chk(16'(width_r), 16'h0, "high byte");
    chk(16'(io_move_r), 16'h1, "io move");
    chk(16'(io_sel_r), 16'h4, "io operand");
    $display("test table done");
    send(fp(31'h20220887) ^ 32'h80000000);
    chk(16'(parity_err_r), 16'h1, "bad parity");
    send(fp(31'h6967BD05));
    chk(16'(src_acc_r), 16'h2, "src acc");
    chk(16'(src_kind_r), 16'h0, "src kind");
    chk(16'({sub_f_r, sub_s_r}), 16'h2, "signs");
    chk(16'(dst_acc_r), 16'h3, "dst acc");
    chk(16'(opnd_ptr_r), 16'h330, "pointers");
    chk(16'(opnd_step_r[2:1]), 16'h9, "steps");
    chk(16'(opnd_inc_reg_r[1]), 16'h10, "inc reg");
    chk(16'(opnd_step_bytes_r), 16'h4, "step bytes");
    chk(16'(opnd_direct_r), 16'h1, "direct");
    chk(16'(opnd_dsel_r[0]), 16'h5, "direct code");
    chk(16'(reserved_err_r), 16'h0, "operands ok");
    send(fp(31'h74020887));
    chk(16'(src_kind_r), 16'h2, "constant one");
    chk(16'(opnd_inc_reg_r[1]), 16'h0F, "first inc reg");
    chk(16'(opnd_dsel_r[0]), 16'h7, "no write");
    send(fp(31'h7A800887));
    chk(16'(conv_op_r), 16'h5, "conversion");
    $display("test operands done");
    send(fp(31'h0261BEEF));
    chk(16'(cond_r), 16'h09, "cond");
    chk(16'({cond_class_r, uncond_r, on_true_r}), 16'h5, "cond kind");
    chk(imm_r, 16'hBEEF, "imm");
    chk(16'({imm_valid_r, reg_a_r}), 16'h21, "imm valid and reg");
    send(fp(31'h04000000));
    chk(16'({cond_class_r, uncond_r, on_true_r}), 16'h8, "io cond");
    send(fp(31'h00000000));
    chk(16'({uncond_r, on_true_r}), 16'h2, "always");
    send(fp(31'h19E30060));
    chk(16'({alu_fn_r, reg_b_r}), 16'h1E3, "alu reg form");
    $display("test branch done");
    send(fp(31'h1F600057));
    chk(16'({to_mem_r, width_r}), 16'h5, "out low byte");
    chk(16'(mem_ptr_r), 16'h2, "move ptr");
    chk(16'({mem_step_r, mem_step_bytes_r}), 16'hD, "post inc");
    chk(16'(mem_inc_r), 16'h17, "move inc");
    chk(16'(io_move_r), 16'h0, "not io");
    send(fp(31'h1EC00030));
    chk(16'({to_mem_r, width_r}), 16'h2, "in integer");
    send(fp(31'h17601234));
    chk(16'({load_fctl_r, load_ioctl_r}), 16'h1, "io ctl");
    chk(ctl_value_r, 16'h1234, "io ctl value");
    send(fp(31'h1740FFFF));
    chk(16'({load_fctl_r, load_ioctl_r}), 16'h2, "float ctl");
    chk(ctl_value_r, 16'h0007, "float ctl value");
    $display("test moves done");
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_word <= fp(31'h10000000);
    @(posedge clk);
    instr_word <= fp(31'h14000000);
    @(negedge clk);
    chk(16'({dec_valid_r, ca_format_r}), 16'h14, "first of pair");
    @(posedge clk);
    instr_valid <= 1'b0;
    @(negedge clk);
    chk(16'({dec_valid_r, ca_format_r}), 16'h15, "second of pair");
    @(negedge clk);
    chk(16'({dec_valid_r, ca_format_r}), 16'h05, "held");
    @(posedge clk);
    reset_n <= 1'b0;
    @(negedge clk);
    chk(16'({dec_valid_r, ca_format_r}), 16'h0, "mid reset");
    chk(imm_r, 16'h0, "imm reset");
    @(posedge clk);
    reset_n <= 1'b1;
    send(fp(31'h1C000000));
    chk(16'(ca_format_r), 16'h8, "after reset");
    $display("test pair and reset done");
    test_done();
  end
endmodule
`default_nettype wire
